// ==== pkg/ddag_map.vh ====
/*
  Constants for the dual data address generator: widths, counts, load targets,
  access modes and reset values.
  Assumes it is included once per design file by its bare name.
*/
`ifndef DDAG_MAP_VH
`define DDAG_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DDAG_IDX_W 16
`define DDAG_PAGE_W 8
`define DDAG_ADDR_W 24
`define DDAG_OFS_W 8
`define DDAG_SEL_W 2

// ----------------------------------------
// Counts
// ----------------------------------------
`define DDAG_GEN_N 2
`define DDAG_SLOT_N 16

// ----------------------------------------
// Access modes
// ----------------------------------------
`define DDAG_MODE_POST_MOD 2'h0
`define DDAG_MODE_PRE_NOUPD 2'h1
`define DDAG_MODE_POST_IMM 2'h2
`define DDAG_MODE_PRE_IMM 2'h3

// ----------------------------------------
// Register load targets
// ----------------------------------------
`define DDAG_LD_INDEX 2'h0
`define DDAG_LD_MODIFY 2'h1
`define DDAG_LD_LENGTH 2'h2
`define DDAG_LD_BASE 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DDAG_RST_IDX 16'h0000
`define DDAG_RST_PAGE 8'h00
`define DDAG_RST_ADDR 24'h000000

`endif

// ==== logic/ddag_dual_gen.v ====
/*
  Two data address generators: one drives the data memory address, the
  other the program memory address, both in the same cycle.
  Assumes the sequencer decodes instructions and presents one access and
  at most one register load per generator per cycle, on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ddag_map.vh"

// How it works
// [RULE_01] Four 16-bit pointers per generator, updated on use
// [RULE_02] Pointer pre/post modified by chosen modify register
// [RULE_03] Nonzero length makes pointer updates circular
// [RULE_04] Wrap stays inside one 64K-word page
// [RULE_05] Shadow register set selected for context switch
// [RULE_06] Pre-modify no update; 8-bit immediate pre/post
// [RULE_07] Both generators output addresses same cycle
// [RULE_08] Page register forms upper eight address bits
// [RULE_09] Out of range adds or subtracts length

module ddag_dual_gen #(
  parameter IDX_W = `DDAG_IDX_W,
  parameter PAGE_W = `DDAG_PAGE_W
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Register bank select, 1 picks the shadow set
  input wire shadow_sel,
  // Access requests, index 0 data side, index 1 program side
  input wire [1:0] acc_en,
  input wire [3:0] acc_mode,
  input wire [3:0] acc_idx,
  input wire [3:0] acc_mod,
  input wire [15:0] acc_imm,
  // Register loads
  input wire [1:0] ld_en,
  input wire [3:0] ld_target,
  input wire [3:0] ld_sel,
  input wire [31:0] ld_data,
  // Page register loads
  input wire [1:0] page_ld_en,
  input wire [15:0] page_ld_data,
  // Address outputs
  output reg [23:0] dm_addr_q,
  output reg dm_addr_vld_q,
  output reg [23:0] pm_addr_q,
  output reg pm_addr_vld_q,
  // Index read-back for the selected bank
  output wire [31:0] cur_index
);

// ----------------------------------------
// Register file: gen*8 + bank*4 + reg
// ----------------------------------------
reg [IDX_W-1:0] idx_q [0:`DDAG_SLOT_N-1];
reg [IDX_W-1:0] mod_q [0:`DDAG_SLOT_N-1];
reg [IDX_W-1:0] len_q [0:`DDAG_SLOT_N-1];
reg [IDX_W-1:0] base_q [0:`DDAG_SLOT_N-1];
reg [PAGE_W-1:0] page_q [0:`DDAG_GEN_N-1];

// ----------------------------------------
// Decode and arithmetic helpers
// ----------------------------------------
// Slot number: generator, then bank, then register
function [3:0] ddag_slot;
  input gen;
  input bank;
  input [`DDAG_SEL_W-1:0] sel;
  begin
    ddag_slot = {gen, bank, sel};
  end
endfunction

// Immediate modes take the step from the instruction
function ddag_is_imm;
  input [`DDAG_SEL_W-1:0] md;
  begin
    ddag_is_imm = (md == `DDAG_MODE_POST_IMM) ||
                  (md == `DDAG_MODE_PRE_IMM);
  end
endfunction

// Pre modes put the modified value on the bus
function ddag_is_pre;
  input [`DDAG_SEL_W-1:0] md;
  begin
    ddag_is_pre = (md == `DDAG_MODE_PRE_NOUPD) ||
                  (md == `DDAG_MODE_PRE_IMM);
  end
endfunction

// Two's complement offset: copy the sign bit upward
function [`DDAG_IDX_W-1:0] ddag_sext;
  input [`DDAG_OFS_W-1:0] ofs;
  begin
    ddag_sext = {{(`DDAG_IDX_W-`DDAG_OFS_W){ofs[`DDAG_OFS_W-1]}}, ofs};
  end
endfunction

// Circular update: wrap by length when outside base..base+len-1
function [15:0] ddag_wrap;
  input [15:0] ptr;
  input [15:0] step;
  input [15:0] len;
  input [15:0] base;
  reg [16:0] sum;
  reg [16:0] rel;
  begin
    sum = {1'b0, ptr} + {1'b0, step};
    rel = {1'b0, sum[15:0]} - {1'b0, base};
    ddag_wrap = sum[15:0];
    // 16-bit arithmetic keeps the buffer inside its page [RULE_04]
    if (len != `DDAG_RST_IDX) begin // [RULE_03]
      if (step[15] && (ptr - base) < (16'h0000 - step)) // [RULE_09]
        ddag_wrap = sum[15:0] + len;
      else if (!step[15] && rel[15:0] >= len) // [RULE_09]
        ddag_wrap = sum[15:0] - len;
      else
        ddag_wrap = sum[15:0];
    end
  end
endfunction

// ----------------------------------------
// Per generator decode
// ----------------------------------------
integer g;
integer k;
reg [3:0] slot [0:`DDAG_GEN_N-1];
reg [3:0] modslot [0:`DDAG_GEN_N-1];
reg [3:0] ldslot [0:`DDAG_GEN_N-1];
reg [1:0] mode [0:`DDAG_GEN_N-1];
reg [1:0] ldtgt [0:`DDAG_GEN_N-1];
reg [15:0] ldword [0:`DDAG_GEN_N-1];
reg [7:0] pgword [0:`DDAG_GEN_N-1];
reg [15:0] step [0:`DDAG_GEN_N-1];
reg [15:0] cur [0:`DDAG_GEN_N-1];
reg [15:0] nxt [0:`DDAG_GEN_N-1];
reg [15:0] outp [0:`DDAG_GEN_N-1];

always @* begin
  for (g = 0; g < `DDAG_GEN_N; g = g + 1) begin
    mode[g] = acc_mode[g*`DDAG_SEL_W +: `DDAG_SEL_W];
    ldtgt[g] = ld_target[g*`DDAG_SEL_W +: `DDAG_SEL_W];
    ldword[g] = ld_data[g*`DDAG_IDX_W +: `DDAG_IDX_W];
    pgword[g] = page_ld_data[g*`DDAG_PAGE_W +: `DDAG_PAGE_W];
    slot[g] = ddag_slot(g[0], shadow_sel,
                        acc_idx[g*`DDAG_SEL_W +: `DDAG_SEL_W]); // [RULE_05]
    modslot[g] = ddag_slot(g[0], shadow_sel,
                           acc_mod[g*`DDAG_SEL_W +: `DDAG_SEL_W]);
    ldslot[g] = ddag_slot(g[0], shadow_sel,
                          ld_sel[g*`DDAG_SEL_W +: `DDAG_SEL_W]);
    cur[g] = idx_q[slot[g]];
    // Immediate is sign extended from eight bits [RULE_06]
    if (ddag_is_imm(mode[g]))
      step[g] = ddag_sext(acc_imm[g*`DDAG_OFS_W +: `DDAG_OFS_W]);
    else
      step[g] = mod_q[modslot[g]]; // [RULE_02]
    nxt[g] = ddag_wrap(cur[g], step[g], len_q[slot[g]], base_q[slot[g]]);
    // Pre modes emit the modified value, post modes the old one
    if (ddag_is_pre(mode[g]))
      outp[g] = nxt[g]; // [RULE_02] [RULE_06]
    else
      outp[g] = cur[g];
  end
end

assign cur_index = {idx_q[{1'b1, shadow_sel, acc_idx[3:2]}],
                    idx_q[{1'b0, shadow_sel, acc_idx[1:0]}]};

// ----------------------------------------
// Register updates
// ----------------------------------------
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    for (k = 0; k < `DDAG_SLOT_N; k = k + 1) begin
      idx_q[k] <= `DDAG_RST_IDX;
      mod_q[k] <= `DDAG_RST_IDX;
      len_q[k] <= `DDAG_RST_IDX;
      base_q[k] <= `DDAG_RST_IDX;
    end
    page_q[0] <= `DDAG_RST_PAGE;
    page_q[1] <= `DDAG_RST_PAGE;
  end else begin
    for (k = 0; k < `DDAG_GEN_N; k = k + 1) begin
      // Access update first so a same-cycle load of the index wins
      if (acc_en[k] && mode[k] != `DDAG_MODE_PRE_NOUPD)
        idx_q[slot[k]] <= nxt[k]; // [RULE_01]
      if (ld_en[k]) begin
        case (ldtgt[k])
          `DDAG_LD_INDEX: idx_q[ldslot[k]] <= ldword[k];
          `DDAG_LD_MODIFY: mod_q[ldslot[k]] <= ldword[k];
          `DDAG_LD_LENGTH: len_q[ldslot[k]] <= ldword[k];
          `DDAG_LD_BASE: base_q[ldslot[k]] <= ldword[k];
          default: base_q[ldslot[k]] <= base_q[ldslot[k]];
        endcase
      end
      if (page_ld_en[k])
        page_q[k] <= pgword[k]; // [RULE_08]
    end
  end
end

// ----------------------------------------
// Address outputs
// ----------------------------------------
always @(posedge clk_sys or negedge rst_b) begin
  if (!rst_b) begin
    dm_addr_q <= `DDAG_RST_ADDR;
    pm_addr_q <= `DDAG_RST_ADDR;
    dm_addr_vld_q <= 1'b0;
    pm_addr_vld_q <= 1'b0;
  end else begin
    // Both sides registered together [RULE_07]
    dm_addr_vld_q <= acc_en[0];
    pm_addr_vld_q <= acc_en[1];
    if (acc_en[0])
      dm_addr_q <= {page_q[0], outp[0]}; // [RULE_08]
    if (acc_en[1])
      pm_addr_q <= {page_q[1], outp[1]}; // [RULE_07]
  end
end

endmodule // ddag_dual_gen
`default_nettype wire

// ==== verification/ddag_chk_assertions.sv ====
/* Port checks for ddag_dual_gen.
   Assumes the bind below reaches every design instance. */
`timescale 1ns/100ps
`default_nettype none
module ddag_chk (
  // Clock, reset, requests
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic shadow_sel,
  input wire logic [1:0] acc_en,
  input wire logic [3:0] acc_mode,
  input wire logic [1:0] ld_en,
  input wire logic [1:0] page_ld_en,
  input wire logic [31:0] cur_index,
  // Addresses
  input wire logic [23:0] dm_addr_q,
  input wire logic dm_addr_vld_q,
  input wire logic [23:0] pm_addr_q,
  input wire logic pm_addr_vld_q
);
  // ----
  // Assertions
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  dm_vld_a: assert property (dm_addr_vld_q == $past(acc_en[0]))
    else $error("dm valid wrong");
  pm_vld_a: assert property (pm_addr_vld_q == $past(acc_en[1]))
    else $error("pm valid wrong");
  dm_hold_a: assert property (!acc_en[0] |=> $stable(dm_addr_q))
    else $error("dm address moved");
  pm_hold_a: assert property (!acc_en[1] |=> $stable(pm_addr_q))
    else $error("pm address moved");
  dm_post_a: assert property (
    acc_en[0] && !acc_mode[0] && !ld_en[0]
    |=> dm_addr_q[15:0] == $past(cur_index[15:0])) else $error("dm post");
  pm_post_a: assert property (
    acc_en[1] && !acc_mode[2] && !ld_en[1]
    |=> pm_addr_q[15:0] == $past(cur_index[31:16])) else $error("pm post");
  // Page only differs after a load
  dm_page_a: assert property (
    acc_en[0] && !page_ld_en[0] ##1 acc_en[0]
    |=> dm_addr_q[23:16] == $past(dm_addr_q[23:16], 1)) else $error("page");
  pm_page_a: assert property (
    acc_en[1] && !page_ld_en[1] ##1 acc_en[1]
    |=> pm_addr_q[23:16] == $past(pm_addr_q[23:16], 1)) else $error("page");
  cover property (acc_en == 2'h3);
  cover property (acc_en[0] ##1 acc_en[0]);
  cover property (shadow_sel && acc_en[0]);
  cover property (acc_en[1] && acc_mode[3:2] == 2'h2);
endmodule // ddag_chk
bind ddag_dual_gen ddag_chk ddag_chk_inst (.clk_sys, .rst_b, .shadow_sel,
  .acc_en, .acc_mode, .ld_en, .page_ld_en, .cur_index, .dm_addr_q,
  .dm_addr_vld_q,
  .pm_addr_q, .pm_addr_vld_q);
`default_nettype wire

// ==== verification/ddag_mem_model.sv ====
/* Memory bus side: latches every address offered on either bus.
   Assumes the clock and reset of the design. */
`timescale 1ns/100ps
`default_nettype none
module ddag_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Address buses
  input wire logic [23:0] dm_addr_q,
  input wire logic dm_addr_vld_q,
  input wire logic [23:0] pm_addr_q,
  input wire logic pm_addr_vld_q,
  // Seen values
  output logic [23:0] dm_seen_q,
  output logic [23:0] pm_seen_q,
  output logic [7:0] dual_cnt_q
);
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dm_seen_q <= 24'h000000;
      pm_seen_q <= 24'h000000;
      dual_cnt_q <= 8'h00;
    end else begin
      if (dm_addr_vld_q) dm_seen_q <= dm_addr_q;
      if (pm_addr_vld_q) pm_seen_q <= pm_addr_q;
      // Both fetches in one cycle
      if (dm_addr_vld_q && pm_addr_vld_q)
        dual_cnt_q <= dual_cnt_q + 8'h01;
    end
  end
endmodule // ddag_mem_model
`default_nettype wire

// ==== verification/ddag_dual_gen_tb.sv ====
/* Bench for ddag_dual_gen with the memory side model.
   Assumes checker bound; inputs change on falling edges. */
`timescale 1ns/100ps
`default_nettype none
module ddag_dual_gen_tb;
  logic clk_sys = 1'b0, rst_b = 1'b0, shadow_sel = 1'b0;
  logic [1:0] acc_en = 2'h0, ld_en = 2'h0, page_ld_en = 2'h0;
  logic [3:0] acc_mode = 4'h0, acc_idx = 4'h0, acc_mod = 4'h0;
  logic [3:0] ld_target = 4'h0, ld_sel = 4'h0;
  logic [15:0] acc_imm = 16'h0000, page_ld_data = 16'h0000;
  logic [31:0] ld_data = 32'h00000000, cur_index;
  logic [23:0] dm_addr_q, pm_addr_q, dm_seen_q, pm_seen_q;
  logic dm_addr_vld_q, pm_addr_vld_q;
  logic [7:0] dual_cnt_q;
  int err_count = 0, n_compared = 0, cyc = 0;
  ddag_dual_gen ddag_dual_gen_inst (.clk_sys, .rst_b, .shadow_sel, .acc_en,
    .acc_mode, .acc_idx, .acc_mod, .acc_imm, .ld_en, .ld_target, .ld_sel,
    .ld_data, .page_ld_en, .page_ld_data, .dm_addr_q, .dm_addr_vld_q,
    .pm_addr_q, .pm_addr_vld_q, .cur_index);
  ddag_mem_model ddag_mem_model_inst (.clk_sys, .rst_b, .dm_addr_q,
    .dm_addr_vld_q, .pm_addr_q, .pm_addr_vld_q, .dm_seen_q, .pm_seen_q,
    .dual_cnt_q);
  always #4 clk_sys = ~clk_sys;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Same fields to both halves; enables pick the generator
  task ld(input logic [1:0] g, input logic [1:0] t, input logic [1:0] s,
      input logic [15:0] d);
    @(negedge clk_sys);
    ld_en = g;
    ld_target = {t, t};
    ld_sel = {s, s};
    ld_data = {d, d};
    @(negedge clk_sys);
    ld_en = 2'h0;
  endtask
  task pg(input logic [1:0] g, input logic [7:0] p);
    @(negedge clk_sys);
    page_ld_en = g;
    page_ld_data = {p, p};
    @(negedge clk_sys);
    page_ld_en = 2'h0;
  endtask
  task acc(input logic [1:0] g, input logic [1:0] m, input logic [1:0] i,
      input logic [1:0] r, input logic [7:0] k);
    @(negedge clk_sys);
    acc_en = g;
    acc_mode = {m, m};
    acc_idx = {i, i};
    acc_mod = {r, r};
    acc_imm = {k, k};
    @(negedge clk_sys);
    acc_en = 2'h0;
  endtask
  task t_linear;
    pg(2'h1, 8'h12);
    ld(2'h1, 2'h0, 2'h0, 16'h0100);
    ld(2'h1, 2'h1, 2'h0, 16'h0004);
    acc(2'h1, 2'h0, 2'h0, 2'h0, 8'h00);
    chk(dm_addr_q, 24'h120100);
    acc(2'h1, 2'h0, 2'h0, 2'h0, 8'h00);
    chk(dm_addr_q, 24'h120104);
    acc(2'h1, 2'h1, 2'h0, 2'h0, 8'h00);
    chk(dm_addr_q, 24'h12010C);
    acc(2'h1, 2'h1, 2'h0, 2'h0, 8'h00);
    chk(dm_addr_q, 24'h12010C);
    acc(2'h1, 2'h2, 2'h0, 2'h0, 8'hF8);
    chk(dm_addr_q, 24'h120108);
    acc(2'h1, 2'h3, 2'h0, 2'h0, 8'hF8);
    chk(dm_addr_q, 24'h1200F8);
    $display("linear test done");
  endtask
  task t_circ;
    pg(2'h2, 8'hFF);
    ld(2'h2, 2'h3, 2'h1, 16'h0200);
    ld(2'h2, 2'h2, 2'h1, 16'h0003);
    ld(2'h2, 2'h0, 2'h1, 16'h0202);
    ld(2'h2, 2'h1, 2'h1, 16'h0002);
    acc(2'h2, 2'h0, 2'h1, 2'h1, 8'h00);
    chk(pm_addr_q, 24'hFF0202);
    acc(2'h2, 2'h0, 2'h1, 2'h1, 8'h00);
    chk(pm_addr_q, 24'hFF0201);
    acc(2'h2, 2'h2, 2'h1, 2'h1, 8'hFE);
    chk(pm_addr_q, 24'hFF0200);
    acc(2'h2, 2'h1, 2'h1, 2'h1, 8'h00);
    chk(pm_addr_q, 24'hFF0200);
    // Backward step wrapped the pointer up to base plus one
    chk(cur_index, 32'h02010000);
    $display("circular test done");
  endtask
  task t_shadow;
    ld(2'h1, 2'h0, 2'h2, 16'h0555);
    shadow_sel = 1'b1;
    ld(2'h1, 2'h0, 2'h2, 16'h0AAA);
    acc(2'h1, 2'h1, 2'h2, 2'h2, 8'h00);
    chk(dm_addr_q, 24'h120AAA);
    chk(cur_index, 32'h00000AAA);
    shadow_sel = 1'b0;
    acc(2'h1, 2'h1, 2'h2, 2'h2, 8'h00);
    chk(dm_addr_q, 24'h120555);
    chk(cur_index, 32'h00000555);
    $display("shadow test done");
  endtask
  // Three back-to-back accesses, page loaded in the first cycle
  task t_burst;
    @(negedge clk_sys);
    acc_en = 2'h3;
    acc_mode = 4'h0;
    acc_idx = 4'h0;
    acc_mod = 4'h0;
    page_ld_en = 2'h3;
    page_ld_data = 16'h5634;
    @(negedge clk_sys);
    page_ld_en = 2'h0;
    chk(dm_addr_q, 24'h1200F8);
    chk(pm_addr_q, 24'hFF0000);
    @(negedge clk_sys);
    chk(dm_addr_q, 24'h3400FC);
    chk(pm_addr_q, 24'h560000);
    @(negedge clk_sys);
    acc_en = 2'h0;
    chk(dm_addr_q, 24'h340100);
    $display("burst test done");
  endtask
  task t_dual;
    acc(2'h3, 2'h1, 2'h1, 2'h1, 8'h00);
    chk(dm_addr_q, 24'h120000);
    chk(pm_addr_q, 24'hFF0200);
    @(negedge clk_sys);
    chk({16'h0000, dual_cnt_q}, 24'h000001);
    chk(pm_seen_q, 24'hFF0200);
    $display("dual test done");
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Run needs about 55 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    t_linear;
    t_circ;
    t_shadow;
    t_dual;
    t_burst;
    print_verdict;
  end
endmodule // ddag_dual_gen_tb
`default_nettype wire
